// file: verilog/sssl_consts.svh
// Constants for the serial command shift and latch link
`ifndef SSSL_CONSTS_SVH
`define SSSL_CONSTS_SVH
`define SSSL_WORD_BITS 20
`define SSSL_CLK_PERIOD_NS 4
`define SSSL_FILT_NS 20
`define SSSL_FILT_CYCLES ((`SSSL_FILT_NS + `SSSL_CLK_PERIOD_NS - 1) / `SSSL_CLK_PERIOD_NS)
`define SSSL_SCK_HALF_CYCLES 8
`define SSSL_SEL_BIT_HI 19
`define SSSL_SEL_BIT_MID 18
`define SSSL_SEL_BIT_LO 17
`define SSSL_READ_SELECT_FIELD_HI 5
`define SSSL_READ_SELECT_FIELD_LO 4
`define SSSL_SYNC_IDLE 4'h6
`endif

// file: verilog/sssl_pkg.sv
// Types shared by both ends of the serial command link
`include "sssl_consts.svh"
package sssl_pkg;
    typedef logic [`SSSL_WORD_BITS-1:0] sssl_word_t;
    typedef logic [1:0] sssl_read_select_field_t;
    typedef enum logic [2:0] {
        SSSL_TGT_CTRL,
        SSSL_TGT_CHOP,
        SSSL_TGT_ENERGY,
        SSSL_TGT_LOAD,
        SSSL_TGT_DRV
    } sssl_target_e;
endpackage : sssl_pkg

// file: verilog/sssl_if.sv
// Serial link wires between master and slave
`timescale 1ns/1ps
`default_nettype none
interface sssl_if;
    logic sck;
    logic sdi;
    logic sdo;
    logic chip_select_low;
    modport master (output sck, output sdi, output chip_select_low, input sdo);
    modport slave (input sck, input sdi, input chip_select_low, output sdo);
endinterface : sssl_if
`default_nettype wire

// file: verilog/sssl_slave.sv
// Device end: serial shift register, pass-through and command latch
// Behaviour
// - Act only while chip select is low
// - Capture input bit on rising serial clock
// - Update output bit after falling serial clock
// - Words travel most significant bit first
// - Master gives at least twenty clocks
// - Extra bits emerge twenty clocks later
// - Chip select stays low whole transaction
// - Rising chip select latches shift register
// - Command is last twenty bits received
// - Serial clock at most half system clock
// - Extra ten percent margin on oscillator
// - Serial clock limits four or eight MHz; master default HALF_CYCLES of 8 gives a 64 ns period, about 15.6 MHz
// - Filter pulses shorter than twenty nanoseconds
// - Chain sends twenty bits per device
// - Top bits select configuration register
// - Read select field picks response word
`timescale 1ns/1ps
`default_nettype none
`include "sssl_consts.svh"
module sssl_slave #(
    parameter int FILT_CYCLES = `SSSL_FILT_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    sssl_if.slave link,
    input wire logic driver_disable_in,
    input wire sssl_pkg::sssl_word_t resp_status_in,
    input wire sssl_pkg::sssl_word_t resp_load_in,
    input wire sssl_pkg::sssl_word_t resp_energy_in,
    output logic driver_disabled_out,
    output logic cmd_valid_out,
    output sssl_pkg::sssl_word_t cmd_word_out,
    output sssl_pkg::sssl_target_e cmd_target_out,
    output sssl_pkg::sssl_read_select_field_t read_select_field_out
);
    import sssl_pkg::*;

    // Positions of the four pins in the synchroniser vector
    localparam int NIN = 4;
    localparam int SCK_IDX = 0;
    localparam int SDI_IDX = 1;
    localparam int CSL_IDX = 2;
    localparam int DIS_IDX = 3;
    localparam logic [NIN-1:0] IN_IDLE = `SSSL_SYNC_IDLE;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] filt;
    logic [NIN-1:0] filt_d;
    sssl_word_t shreg;
    sssl_word_t cmd;
    sssl_target_e cmd_target;
    sssl_read_select_field_t read_select_field;
    logic sdo;

    function automatic sssl_target_e decode_target(input sssl_word_t w);
        if (!w[`SSSL_SEL_BIT_HI])
            decode_target = SSSL_TGT_CTRL;
        else if (!w[`SSSL_SEL_BIT_MID])
            decode_target = w[`SSSL_SEL_BIT_LO] ? SSSL_TGT_ENERGY : SSSL_TGT_CHOP;
        else
            decode_target = w[`SSSL_SEL_BIT_LO] ? SSSL_TGT_DRV : SSSL_TGT_LOAD;
    endfunction : decode_target

    assign raw = {driver_disable_in, link.chip_select_low, link.sdi, link.sck};

    // Two flops per pin; only sync2 reads sync1
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sync1 <= IN_IDLE;
            sync2 <= IN_IDLE;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // Glitch filter: level must hold FILT_CYCLES before it is accepted
    genvar g;
    generate
        for (g = 0; g < NIN; g = g + 1)
        begin : gen_filt
            logic [7:0] cnt;
            logic level;
            assign filt[g] = level;
            always_ff @(posedge clk_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                begin
                    cnt <= 8'h00;
                    level <= IN_IDLE[g];
                end
                else if (sync2[g] == level)
                    cnt <= 8'h00;
                else if (cnt >= 8'(FILT_CYCLES - 1))
                begin
                    cnt <= 8'h00;
                    level <= sync2[g];
                end
                else
                    cnt <= cnt + 8'h01;
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            filt_d <= IN_IDLE;
        else
            filt_d <= filt;
    end

    // Edges come from filtered levels, so a glitch never shifts
    wire sck_rise = filt[SCK_IDX] && !filt_d[SCK_IDX];
    wire sck_fall = !filt[SCK_IDX] && filt_d[SCK_IDX];
    wire cs_fall = !filt[CSL_IDX] && filt_d[CSL_IDX];
    wire cs_rise = filt[CSL_IDX] && !filt_d[CSL_IDX];
    wire sel = !filt[CSL_IDX];

    sssl_word_t resp;
    // Unused code 3 answers like code 2
    always_comb
    begin
        if (read_select_field == 2'h0)
            resp = resp_status_in;
        else if (read_select_field == 2'h1)
            resp = resp_load_in;
        else
            resp = resp_energy_in;
    end

    // Shift register doubles as the 20-stage chain delay
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            shreg <= '0;
        else if (cs_fall)
            shreg <= resp;
        else if (sel && sck_rise)
            shreg <= {shreg[`SSSL_WORD_BITS-2:0], filt[SDI_IDX]};
    end

    // Preload on select fall so the first bit stands before the first rise
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            sdo <= 1'b0;
        else if (cs_fall)
            sdo <= resp[`SSSL_WORD_BITS-1];
        else if (sel && sck_fall)
            sdo <= shreg[`SSSL_WORD_BITS-1];
    end

    // Command and its decoded target change together on a select rise
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cmd <= '0;
            cmd_target <= SSSL_TGT_CTRL;
        end
        else if (cs_rise)
        begin
            cmd <= shreg;
            cmd_target <= decode_target(shreg);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cmd_valid_out <= 1'b0;
        else
            cmd_valid_out <= cs_rise;
    end

    // Only a driver configuration write moves the read select
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            read_select_field <= 2'h0;
        else if (cs_rise && decode_target(shreg) == SSSL_TGT_DRV)
            read_select_field <= shreg[`SSSL_READ_SELECT_FIELD_HI:`SSSL_READ_SELECT_FIELD_LO];
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            driver_disabled_out <= 1'b0;
        else
            driver_disabled_out <= filt[DIS_IDX];
    end

    assign link.sdo = sdo;
    assign cmd_word_out = cmd;
    assign cmd_target_out = cmd_target;
    assign read_select_field_out = read_select_field;
endmodule : sssl_slave
`default_nettype wire

// file: verilog/sssl_master.sv
// Master end: shifts a word of chained 20-bit commands out and back in
`timescale 1ns/1ps
`default_nettype none
`include "sssl_consts.svh"
module sssl_master #(
    parameter int MAX_BITS = 64,
    parameter int HALF_CYCLES = `SSSL_SCK_HALF_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    sssl_if.master link,
    input wire logic start_in,
    input wire logic [7:0] nbits_in,
    input wire logic [MAX_BITS-1:0] tx_in,
    output logic busy_out,
    output logic done_out,
    output logic [MAX_BITS-1:0] rx_out
);
    import sssl_pkg::*;

    typedef enum logic [1:0] {SSSL_IDLE, SSSL_LOW, SSSL_HIGH, SSSL_END} sssl_mstate_e;
    sssl_mstate_e state;
    logic [7:0] div;
    logic [7:0] left;
    logic [MAX_BITS-1:0] tx;
    logic sdo_s1;
    logic sdo_s2;
    logic sck;
    logic csl;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
        end
        else
        begin
            sdo_s1 <= link.sdo;
            sdo_s2 <= sdo_s1;
        end
    end

    // Slow clock keeps under half the slave clock with margin
    wire tick = (div == 8'(HALF_CYCLES - 1));

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state <= SSSL_IDLE;
            div <= 8'h00;
            left <= 8'h00;
            tx <= '0;
            rx_out <= '0;
            sck <= 1'b0;
            csl <= 1'b1;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            div <= (state == SSSL_IDLE || tick) ? 8'h00 : div + 8'h01;
            case (state)
                SSSL_IDLE:
                    if (start_in)
                    begin
                        // Chains send 20 bits per device, minimum one device
                        left <= (nbits_in < 8'(`SSSL_WORD_BITS)) ? 8'(`SSSL_WORD_BITS) : nbits_in;
                        tx <= tx_in;
                        csl <= 1'b0;
                        state <= SSSL_LOW;
                    end
                SSSL_LOW:
                    if (tick)
                    begin
                        sck <= 1'b1;
                        rx_out <= {rx_out[MAX_BITS-2:0], sdo_s2};
                        state <= SSSL_HIGH;
                    end
                SSSL_HIGH:
                    if (tick)
                    begin
                        sck <= 1'b0;
                        tx <= {tx[MAX_BITS-2:0], 1'b0};
                        left <= left - 8'h01;
                        state <= (left == 8'h01) ? SSSL_END : SSSL_LOW;
                    end
                SSSL_END:
                    if (tick)
                    begin
                        csl <= 1'b1;
                        done_out <= 1'b1;
                        state <= SSSL_IDLE;
                    end
                default:
                    state <= SSSL_IDLE;
            endcase
        end
    end

    // MSB of the left-aligned word goes first
    assign link.sdi = tx[MAX_BITS-1];
    assign link.sck = sck;
    assign link.chip_select_low = csl;
    assign busy_out = (state != SSSL_IDLE);
endmodule : sssl_master
`default_nettype wire

// file: tb/sssl_link_asserts.sv
// Wire-level checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sssl_link_asserts (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic chip_select_low
);
    logic sck_q;
    logic csl_q;
    logic [7:0] rises;
    logic [19:0] hist;
    logic [4:0] since;
    logic [3:0] idle_run;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in) {sck_q, csl_q} <= 2'h1;
        else {sck_q, csl_q} <= {sck, chip_select_low};
    // Rise count restarts at each select fall
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in) rises <= 8'h0;
        else if (csl_q && !chip_select_low) rises <= 8'h0;
        else if (sck && !sck_q) rises <= rises + 8'h1;
    // No reset needed, read only after twenty rises
    always_ff @(posedge clk_in)
        if (sck && !sck_q) hist <= {hist[18:0], sdi};
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in) since <= 5'h1F;
        else if ((sck_q && !sck) || (csl_q && !chip_select_low)) since <= 5'h0;
        else if (since != 5'h1F) since <= since + 5'h1;
    // Select-high run length, counted instead of a long repetition
    always_ff @(posedge clk_in or posedge sys_rst_in)
        if (sys_rst_in) idle_run <= 4'h0;
        else if (!chip_select_low) idle_run <= 4'h0;
        else if (idle_run != 4'hF) idle_run <= idle_run + 4'h1;
    a_idle_quiet: assert property (chip_select_low && idle_run >= 4'hB |-> $stable(sdo))
        else $error("sdo moved while deselected");
    a_sdo_hold: assert property ($rose(sck) |=> $stable(sdo) [*8])
        else $error("sdo moved during sck high");
    a_sdo_late: assert property ($changed(sdo) |-> since inside {[5'h3:5'hC]})
        else $error("sdo change not tied to a falling edge");
    a_pass_delay: assert property (sck && !sck_q && rises >= 8'h14 |-> sdo == hist[19])
        else $error("pass-through bit not twenty clocks late");
    a_min_clocks: assert property (chip_select_low && !csl_q |-> rises >= 8'h14)
        else $error("frame shorter than twenty clocks");
    a_sck_framed: assert property ($changed(sck) |-> !chip_select_low)
        else $error("sck moved outside a frame");
    a_sck_rate: assert property ($changed(sck) |=> $stable(sck))
        else $error("sck phase shorter than two clocks");
    a_select_edge: assert property ($changed(chip_select_low) |-> !sck && $stable(sck))
        else $error("select moved with sck high");
    c_single: cover property ($rose(chip_select_low) && rises == 8'h14);
    c_long: cover property ($rose(chip_select_low) && rises == 8'h18);
    c_chain: cover property ($rose(chip_select_low) && rises == 8'h28);
endmodule : sssl_link_asserts
`default_nettype wire

// file: tb/spi_slave_shift_latch_test.sv
// Self-checking bench joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
module spi_slave_shift_latch_test;
    import sssl_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start = 1'b0;
    logic dis = 1'b0;
    logic [7:0] nbits = 8'h14;
    logic [63:0] tx = 64'h0;
    logic [63:0] rx;
    logic done, cv, dis_o, busy;
    sssl_word_t cw;
    sssl_target_e ct;
    sssl_read_select_field_t rs;
    sssl_word_t resp [3] = '{20'h0, 20'h0, 20'h0};
    logic [1:0] rd = 2'h0;
    logic [2:0] codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0] lens [3] = '{8'h14, 8'h18, 8'h28};
    logic [22:0] q_cmd [$];
    logic [63:0] q_rx [$];
    logic [63:0] q_msk [$];
    int n_errors = 0;
    int checked = 0;
    sssl_if link ();
    // Sck period of 32 clocks stays under 8 MHz and settles sdo before each rise
    sssl_master #(.HALF_CYCLES(16)) i_sssl_master (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .link(link), .start_in(start), .nbits_in(nbits), .tx_in(tx), .busy_out(busy),
        .done_out(done), .rx_out(rx));
    sssl_slave i_sssl_slave (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link),
        .driver_disable_in(dis), .resp_status_in(resp[0]), .resp_load_in(resp[1]),
        .resp_energy_in(resp[2]), .driver_disabled_out(dis_o), .cmd_valid_out(cv),
        .cmd_word_out(cw), .cmd_target_out(ct), .read_select_field_out(rs));
    sssl_link_asserts i_sssl_link_asserts (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo), .chip_select_low(link.chip_select_low));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Random filler ahead of the command exercises the pass-through path
    task automatic xfer(input logic [7:0] n, input logic [19:0] c);
        logic [63:0] t;
        int k;
        t = {12'h0, 32'($urandom), c} << (64 - n);
        resp[0] = 20'($urandom);
        resp[1] = 20'($urandom);
        resp[2] = 20'($urandom);
        q_cmd.push_back({c[19] ? 3'(SSSL_TGT_CHOP) + 3'(c[18:17]) : 3'(SSSL_TGT_CTRL), c});
        q_rx.push_back(({44'h0, resp[rd[1] ? 2'h2 : rd]} << (n - 20)) | (t >> (84 - n)));
        q_msk.push_back((64'h1 << n) - 64'h1);
        if (c[19:17] == 3'h7) rd = c[5:4];
        nbits = n;
        tx = t;
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        check("busy", busy, 1'b1);
        for (k = 0; k < 2000 && !done; k++) @(negedge clk_in);
        check("done", done, 1'b1);
        check("idle", busy, 1'b0);
        repeat (30) @(negedge clk_in);
        check("read_select_field", rs, rd);
    endtask : xfer
    // Looked at half a cycle after launch, while the pulse stands
    always @(negedge clk_in)
    begin
        if (cv) check("cmd", {ct, cw}, q_cmd.pop_front());
        if (done) check("rx", rx & q_msk.pop_front(), q_rx.pop_front());
    end
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end
    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'hDF4F2DAB));
        repeat (20) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (12) @(negedge clk_in);
        for (int i = 0; i < 15; i++) xfer(lens[i % 3], {codes[i % 5], 17'($urandom)});
        // Short pulse must vanish, long one must pass
        dis = 1'b1;
        repeat (3) @(negedge clk_in);
        dis = 1'b0;
        repeat (12) @(negedge clk_in);
        check("dis", dis_o, 1'b0);
        dis = 1'b1;
        repeat (12) @(negedge clk_in);
        check("dis", dis_o, 1'b1);
        dis = 1'b0;
        check("pending", 64'(q_cmd.size() + q_rx.size()), 64'h0);
        end_of_test();
    end
endmodule : spi_slave_shift_latch_test
`default_nettype wire
